// *** core/gpm_pkg.sv ***
// =====================================================================
// Shared constants for the port-4 data / port-5 function-select block
// =====================================================================
package gpm_pkg;

  // =====================================================================
  // Register byte addresses
  // =====================================================================
  localparam logic [31:0] GPM_P4_DIR_ADR = 32'hfff83044;  // Port-4 direction
  localparam logic [31:0] GPM_P4_OUT_ADR = 32'hfff83048;  // port4_output_value
  localparam logic [31:0] GPM_P4_IN_ADR  = 32'hfff8304c;  // port4_pin_level
  localparam logic [31:0] GPM_P5_CFG_ADR = 32'hfff83050;  // port5_function_select
  localparam logic [31:0] GPM_P5_DIR_ADR = 32'hfff83054;  // Port-5 output enables
  localparam logic [31:0] GPM_P5_OUT_ADR = 32'hfff83058;  // Port-5 data output
  localparam logic [31:0] GPM_P5_IN_ADR  = 32'hfff8305c;  // Port-5 pin levels

  // =====================================================================
  // Field positions and widths
  // =====================================================================
  localparam int GPM_P4_BIT    = 10;  // The single port-4 bit
  localparam int GPM_P5_PINS   = 13;  // Pins on port 5
  localparam int GPM_FIELD_W   = 2;   // Width of one function field
  localparam int GPM_CFG_BITS  = 26;  // Implemented function-select bits

  // =====================================================================
  // Reset values
  // =====================================================================
  localparam logic        GPM_P4_OUT_RST = 1'h0;
  localparam logic        GPM_P4_DIR_RST = 1'h0;
  localparam logic [25:0] GPM_P5_CFG_RST = 26'h0000000;
  localparam logic [12:0] GPM_P5_DIR_RST = 13'h0000;
  localparam logic [12:0] GPM_P5_OUT_RST = 13'h0000;

  // =====================================================================
  // Function codes of one port-5 field
  // =====================================================================
  localparam logic [1:0] GPM_FN_GPIO = 2'h0;  // Plain bidirectional I/O
  localparam logic [1:0] GPM_FN_ALT1 = 2'h1;
  localparam logic [1:0] GPM_FN_ALT2 = 2'h2;
  localparam logic [1:0] GPM_FN_ALT3 = 2'h3;

  // =====================================================================
  // Whole block state
  // =====================================================================
  typedef struct packed {
    logic        ack;         // Bus answer
    logic [31:0] rdata;       // Read data
    logic        p4_out_val;  // Stored port-4 output bit
    logic        p4_dir;      // Port-4 output enable
    logic [25:0] p5_cfg;      // Function fields
    logic [12:0] p5_dir;      // Port-5 output enables
    logic [12:0] p5_out_val;  // Port-5 output data
    logic        p4_s1;       // Port-4 synchroniser
    logic        p4_s2;
    logic        p4_s3;
    logic        p4_lvl;      // Accepted port-4 level
    logic [12:0] p5_s1;       // Port-5 synchronisers
    logic [12:0] p5_s2;
    logic [12:0] p5_s3;
    logic [12:0] p5_lvl;      // Accepted port-5 levels
    logic        p4_pin_o;
    logic        p4_pin_oe;
    logic [12:0] p5_pin_o;
    logic [12:0] p5_pin_oe;
    logic        ser1_rx;
    logic        ser2_rx;
    logic        ser1_cts;
    logic        kbd_din;
    logic        tw0_clk_in;
    logic        tw0_dat_in;
    logic        tw1_clk_in;
    logic        tw1_dat_in;
    logic        ssp_rx;
    logic        irq0_n;
    logic        irq1_n;
    logic        usb_ovc;
  } gpm_state_t;

endpackage

// *** core/gpm_top.sv ***
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
// Contract
// - Port-4 output bit drives pin when output
// - Only bit 10 of port-4 output stores
// - Port-4 output register resets to zero
// - Port-4 input bit shows live pin level
// - Port-4 input reserved bits read zero
// - Thirteen two-bit fields, reset zero
// - Code 00 selects plain I/O, default
// - Pin 0 code 01 outputs serial0 transmit
// - Pin 3 code 01 inputs serial1 receive
// - Pin 4: serial2 tx, serial1_clear_to_send, keyboard clock
// - Pin 5: serial2 rx, serial1_request_to_send, keyboard data
// - Pin 6: twowire0 clock, frame, output A
// - Pin 7: twowire0 data, sync tx, output B
// - Pin 8: twowire1 clock, sync clock, row2
// - Pin 9: twowire1 data, sync rx, row3
// - Pin 10: watchdog, USB power enable
// - Pins 11/12: interrupts, USB overcurrent
// - Port-5 enables act only in I/O mode
module gpm_top
  import gpm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic             WB_ACK_O,
  output logic      [31:0] WB_DAT_O,
  input  wire logic        PORT4_PIN_IN,
  output logic             PORT4_PIN_OUT,
  output logic             PORT4_PIN_OE,
  input  wire logic [12:0] PORT5_PIN_IN,
  output logic      [12:0] PORT5_PIN_OUT,
  output logic      [12:0] PORT5_OUTPUT_ENABLES,
  input  wire logic        SERIAL0_TX,
  input  wire logic        SERIAL2_TX,
  input  wire logic        SERIAL1_REQUEST_TO_SEND,
  input  wire logic        KEYBOARD_PORT_CLOCK,
  input  wire logic        KEYBOARD_PORT_DATA_OUT,
  input  wire logic        KEYBOARD_PORT_DATA_OE,
  input  wire logic        TWOWIRE0_CLOCK_OUT,
  input  wire logic        TWOWIRE0_CLOCK_OE,
  input  wire logic        TWOWIRE0_DATA_OUT,
  input  wire logic        TWOWIRE0_DATA_OE,
  input  wire logic        TWOWIRE1_CLOCK_OUT,
  input  wire logic        TWOWIRE1_CLOCK_OE,
  input  wire logic        TWOWIRE1_DATA_OUT,
  input  wire logic        TWOWIRE1_DATA_OE,
  input  wire logic        SYNC_SERIAL_FRAME,
  input  wire logic        SYNC_SERIAL_TX,
  input  wire logic        SYNC_SERIAL_CLOCK,
  input  wire logic        OUTPUT_A,
  input  wire logic        OUTPUT_B,
  input  wire logic        KEYPAD_ROW_2,
  input  wire logic        KEYPAD_ROW_3,
  input  wire logic        WATCHDOG_OUT_N,
  input  wire logic        USB_POWER_ENABLE,
  output logic             SERIAL1_RX,
  output logic             SERIAL2_RX,
  output logic             SERIAL1_CLEAR_TO_SEND,
  output logic             KEYBOARD_PORT_DATA_IN,
  output logic             TWOWIRE0_CLOCK_IN,
  output logic             TWOWIRE0_DATA_IN,
  output logic             TWOWIRE1_CLOCK_IN,
  output logic             TWOWIRE1_DATA_IN,
  output logic             SYNC_SERIAL_RX,
  output logic             EXT_INTERRUPT0_N,
  output logic             EXT_INTERRUPT1_N,
  output logic             USB_OVERCURRENT_IN
);

  // =====================================================================
  // State and helpers
  // =====================================================================
  gpm_state_t  r;        // Registered state
  gpm_state_t  next_r;   // Next state
  logic        req;      // New bus request not yet answered
  logic        wr;       // Write takes effect at this edge
  logic [31:0] wmask;    // Byte-lane mask from select
  logic [31:0] rd;       // Read value for the addressed word
  logic [1:0]  fn [13];  // Decoded function code per pin
  logic [31:0] m_cfg;    // Byte-merged write word, function select
  logic [31:0] m_dir;    // Byte-merged write word, port-5 enables
  logic [31:0] m_out;    // Byte-merged write word, port-5 data

  // Apply byte enables to a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  // Address match on whole words
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a[31:2] == off[31:2]);
  endfunction

  // =====================================================================
  // Next-state logic
  // =====================================================================
  // One process computes every next value; the bus, the synchronisers and
  // the pin multiplexers all live here so the state stays one struct.
  always_comb begin
    next_r = r;
    req    = WB_CYC_I && WB_STB_I && !r.ack;
    // Writes land on the edge where the master sees ack high
    wr     = WB_CYC_I && WB_STB_I && WB_WE_I && r.ack;
    wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    // Merging works on whole words; only the implemented low bits are kept later
    m_cfg  = merge({6'h00, r.p5_cfg}, WB_DAT_I, wmask);
    m_dir  = merge({19'h00000, r.p5_dir}, WB_DAT_I, wmask);
    m_out  = merge({19'h00000, r.p5_out_val}, WB_DAT_I, wmask);
    for (int i = 0; i < GPM_P5_PINS; i++) begin
      fn[i] = r.p5_cfg[GPM_FIELD_W*i +: GPM_FIELD_W];
    end

    // Read value; unused and reserved bits stay zero
    rd = 32'h00000000;
    if (hit(WB_ADR_I, GPM_P4_OUT_ADR)) begin
      rd[GPM_P4_BIT] = r.p4_out_val;
    end else if (hit(WB_ADR_I, GPM_P4_IN_ADR)) begin
      rd[GPM_P4_BIT] = r.p4_lvl;
    end else if (hit(WB_ADR_I, GPM_P4_DIR_ADR)) begin
      rd[GPM_P4_BIT] = r.p4_dir;
    end else if (hit(WB_ADR_I, GPM_P5_CFG_ADR)) begin
      rd[GPM_CFG_BITS-1:0] = r.p5_cfg;
    end else if (hit(WB_ADR_I, GPM_P5_DIR_ADR)) begin
      rd[GPM_P5_PINS-1:0] = r.p5_dir;
    end else if (hit(WB_ADR_I, GPM_P5_OUT_ADR)) begin
      rd[GPM_P5_PINS-1:0] = r.p5_out_val;
    end else if (hit(WB_ADR_I, GPM_P5_IN_ADR)) begin
      rd[GPM_P5_PINS-1:0] = r.p5_lvl;
    end

    // Ack one cycle after the request, then drop; unmapped reads give zero
    next_r.ack = req;
    if (req) begin
      next_r.rdata = rd;
    end

    // Register writes; writes to unmapped words are accepted and dropped
    if (wr) begin
      if (hit(WB_ADR_I, GPM_P4_OUT_ADR)) begin
        next_r.p4_out_val = wmask[GPM_P4_BIT] ? WB_DAT_I[GPM_P4_BIT] : r.p4_out_val;
      end
      if (hit(WB_ADR_I, GPM_P4_DIR_ADR)) begin
        next_r.p4_dir = wmask[GPM_P4_BIT] ? WB_DAT_I[GPM_P4_BIT] : r.p4_dir;
      end
      if (hit(WB_ADR_I, GPM_P5_CFG_ADR)) begin
        next_r.p5_cfg = m_cfg[GPM_CFG_BITS-1:0];
      end
      if (hit(WB_ADR_I, GPM_P5_DIR_ADR)) begin
        next_r.p5_dir = m_dir[GPM_P5_PINS-1:0];
      end
      if (hit(WB_ADR_I, GPM_P5_OUT_ADR)) begin
        next_r.p5_out_val = m_out[GPM_P5_PINS-1:0];
      end
    end

    // Pin synchronisers: a level is accepted once stages two and three agree
    next_r.p4_s1 = PORT4_PIN_IN;
    next_r.p4_s2 = r.p4_s1;
    next_r.p4_s3 = r.p4_s2;
    if (r.p4_s2 == r.p4_s3) begin
      next_r.p4_lvl = r.p4_s3;
    end
    next_r.p5_s1 = PORT5_PIN_IN;
    next_r.p5_s2 = r.p5_s1;
    next_r.p5_s3 = r.p5_s2;
    for (int i = 0; i < GPM_P5_PINS; i++) begin
      if (r.p5_s2[i] == r.p5_s3[i]) begin
        next_r.p5_lvl[i] = r.p5_s3[i];
      end
    end

    // Port-4 pin is always plain I/O here
    next_r.p4_pin_o  = r.p4_out_val;
    next_r.p4_pin_oe = r.p4_dir;

    // Port-5 default: plain I/O for code 00, pin released otherwise.
    // Reserved codes leave the pin undriven, the safest choice for a board.
    for (int i = 0; i < GPM_P5_PINS; i++) begin
      next_r.p5_pin_o[i]  = r.p5_out_val[i];
      next_r.p5_pin_oe[i] = (fn[i] == GPM_FN_GPIO) && r.p5_dir[i];
    end

    // Pin 0
    if (fn[0] == GPM_FN_ALT1) begin
      next_r.p5_pin_o[0]  = SERIAL0_TX;
      next_r.p5_pin_oe[0] = 1'b1;
    end
    // Pin 4
    unique case (fn[4])
      GPM_FN_ALT1: begin
        next_r.p5_pin_o[4]  = SERIAL2_TX;
        next_r.p5_pin_oe[4] = 1'b1;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[4]  = KEYBOARD_PORT_CLOCK;
        next_r.p5_pin_oe[4] = 1'b1;
      end
      GPM_FN_GPIO, GPM_FN_ALT2: begin
        // Plain I/O or clear-to-send input
      end
    endcase
    // Pin 5
    unique case (fn[5])
      GPM_FN_ALT2: begin
        next_r.p5_pin_o[5]  = SERIAL1_REQUEST_TO_SEND;
        next_r.p5_pin_oe[5] = 1'b1;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[5]  = KEYBOARD_PORT_DATA_OUT;
        next_r.p5_pin_oe[5] = KEYBOARD_PORT_DATA_OE;
      end
      GPM_FN_GPIO, GPM_FN_ALT1: begin
        // Plain I/O or serial2 receive input
      end
    endcase
    // Pins 6 to 9 share one layout: two-wire line, sync serial, third output
    unique case (fn[6])
      GPM_FN_ALT1: begin
        next_r.p5_pin_o[6]  = TWOWIRE0_CLOCK_OUT;
        next_r.p5_pin_oe[6] = TWOWIRE0_CLOCK_OE;
      end
      GPM_FN_ALT2: begin
        next_r.p5_pin_o[6]  = SYNC_SERIAL_FRAME;
        next_r.p5_pin_oe[6] = 1'b1;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[6]  = OUTPUT_A;
        next_r.p5_pin_oe[6] = 1'b1;
      end
      GPM_FN_GPIO: begin
      end
    endcase
    unique case (fn[7])
      GPM_FN_ALT1: begin
        next_r.p5_pin_o[7]  = TWOWIRE0_DATA_OUT;
        next_r.p5_pin_oe[7] = TWOWIRE0_DATA_OE;
      end
      GPM_FN_ALT2: begin
        next_r.p5_pin_o[7]  = SYNC_SERIAL_TX;
        next_r.p5_pin_oe[7] = 1'b1;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[7]  = OUTPUT_B;
        next_r.p5_pin_oe[7] = 1'b1;
      end
      GPM_FN_GPIO: begin
      end
    endcase
    unique case (fn[8])
      GPM_FN_ALT1: begin
        next_r.p5_pin_o[8]  = TWOWIRE1_CLOCK_OUT;
        next_r.p5_pin_oe[8] = TWOWIRE1_CLOCK_OE;
      end
      GPM_FN_ALT2: begin
        next_r.p5_pin_o[8]  = SYNC_SERIAL_CLOCK;
        next_r.p5_pin_oe[8] = 1'b1;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[8]  = KEYPAD_ROW_2;
        next_r.p5_pin_oe[8] = 1'b1;
      end
      GPM_FN_GPIO: begin
      end
    endcase
    unique case (fn[9])
      GPM_FN_ALT1: begin
        next_r.p5_pin_o[9]  = TWOWIRE1_DATA_OUT;
        next_r.p5_pin_oe[9] = TWOWIRE1_DATA_OE;
      end
      GPM_FN_ALT3: begin
        next_r.p5_pin_o[9]  = KEYPAD_ROW_3;
        next_r.p5_pin_oe[9] = 1'b1;
      end
      GPM_FN_GPIO, GPM_FN_ALT2: begin
        // Plain I/O or sync serial receive input
      end
    endcase
    // Pin 10
    if (fn[10] == GPM_FN_ALT1) begin
      next_r.p5_pin_o[10]  = WATCHDOG_OUT_N;
      next_r.p5_pin_oe[10] = 1'b1;
    end else if (fn[10] == GPM_FN_ALT2) begin
      next_r.p5_pin_o[10]  = USB_POWER_ENABLE;
      next_r.p5_pin_oe[10] = 1'b1;
    end

    // Inputs to peripherals; deselected lines rest at their idle level
    next_r.ser1_rx    = (fn[3] == GPM_FN_ALT1) ? r.p5_lvl[3] : 1'b1;
    next_r.ser1_cts   = (fn[4] == GPM_FN_ALT2) ? r.p5_lvl[4] : 1'b1;
    next_r.ser2_rx    = (fn[5] == GPM_FN_ALT1) ? r.p5_lvl[5] : 1'b1;
    next_r.kbd_din    = (fn[5] == GPM_FN_ALT3) ? r.p5_lvl[5] : 1'b1;
    next_r.tw0_clk_in = (fn[6] == GPM_FN_ALT1) ? r.p5_lvl[6] : 1'b1;
    next_r.tw0_dat_in = (fn[7] == GPM_FN_ALT1) ? r.p5_lvl[7] : 1'b1;
    next_r.tw1_clk_in = (fn[8] == GPM_FN_ALT1) ? r.p5_lvl[8] : 1'b1;
    next_r.tw1_dat_in = (fn[9] == GPM_FN_ALT1) ? r.p5_lvl[9] : 1'b1;
    next_r.ssp_rx     = (fn[9] == GPM_FN_ALT2) ? r.p5_lvl[9] : 1'b0;
    next_r.irq0_n     = (fn[11] == GPM_FN_ALT1) ? r.p5_lvl[11] : 1'b1;
    next_r.irq1_n     = (fn[12] == GPM_FN_ALT1) ? r.p5_lvl[12] : 1'b1;
    next_r.usb_ovc    = (fn[12] == GPM_FN_ALT2) ? r.p5_lvl[12] : 1'b0;

    // Synchronous reset: everything clear, active-low and idle-high lines high
    if (SYS_RST) begin
      next_r            = '0;
      next_r.p4_out_val = GPM_P4_OUT_RST;
      next_r.p4_dir     = GPM_P4_DIR_RST;
      next_r.p5_cfg     = GPM_P5_CFG_RST;
      next_r.p5_dir     = GPM_P5_DIR_RST;
      next_r.p5_out_val = GPM_P5_OUT_RST;
      next_r.ser1_rx    = 1'b1;
      next_r.ser1_cts   = 1'b1;
      next_r.ser2_rx    = 1'b1;
      next_r.kbd_din    = 1'b1;
      next_r.tw0_clk_in = 1'b1;
      next_r.tw0_dat_in = 1'b1;
      next_r.tw1_clk_in = 1'b1;
      next_r.tw1_dat_in = 1'b1;
      next_r.irq0_n     = 1'b1;
      next_r.irq1_n     = 1'b1;
    end
  end

  // =====================================================================
  // State register
  // =====================================================================
  always_ff @(posedge CLK) begin
    r <= next_r;
  end

  // =====================================================================
  // Outputs, each straight from a flip-flop
  // =====================================================================
  assign WB_ACK_O              = r.ack;
  assign WB_DAT_O              = r.rdata;
  assign PORT4_PIN_OUT         = r.p4_pin_o;
  assign PORT4_PIN_OE          = r.p4_pin_oe;
  assign PORT5_PIN_OUT         = r.p5_pin_o;
  assign PORT5_OUTPUT_ENABLES  = r.p5_pin_oe;
  assign SERIAL1_RX            = r.ser1_rx;
  assign SERIAL2_RX            = r.ser2_rx;
  assign SERIAL1_CLEAR_TO_SEND = r.ser1_cts;
  assign KEYBOARD_PORT_DATA_IN = r.kbd_din;
  assign TWOWIRE0_CLOCK_IN     = r.tw0_clk_in;
  assign TWOWIRE0_DATA_IN      = r.tw0_dat_in;
  assign TWOWIRE1_CLOCK_IN     = r.tw1_clk_in;
  assign TWOWIRE1_DATA_IN      = r.tw1_dat_in;
  assign SYNC_SERIAL_RX        = r.ssp_rx;
  assign EXT_INTERRUPT0_N      = r.irq0_n;
  assign EXT_INTERRUPT1_N      = r.irq1_n;
  assign USB_OVERCURRENT_IN    = r.usb_ovc;

  // =====================================================================
  // Assertions
  // =====================================================================
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);

  a_p4_pin_drive: assert property (
    r.p4_dir && !$past(SYS_RST) |=> PORT4_PIN_OE && PORT4_PIN_OUT == $past(r.p4_out_val))
    else $error("port-4 pin does not follow stored bit");
  a_p4_write_bit: assert property (
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && hit(WB_ADR_I, GPM_P4_OUT_ADR) && WB_SEL_I[1]
    |=> r.p4_out_val == $past(WB_DAT_I[GPM_P4_BIT]))
    else $error("port-4 output write lost");
  a_p4_reset_zero: assert property (
    $past(SYS_RST) |-> r.p4_out_val == 1'b0 && PORT5_OUTPUT_ENABLES == 13'h0000)
    else $error("output state not zero after reset");
  a_p4_read_level: assert property (
    WB_ACK_O && !WB_WE_I && hit(WB_ADR_I, GPM_P4_IN_ADR) |-> WB_DAT_O[GPM_P4_BIT] == $past(r.p4_lvl))
    else $error("port-4 read does not show pin level");
  a_p4_read_rsvd: assert property (
    WB_ACK_O && hit(WB_ADR_I, GPM_P4_IN_ADR) |-> WB_DAT_O[31:11] == 21'h000000 && WB_DAT_O[9:0] == 10'h000)
    else $error("port-4 reserved bits not zero");
  a_cfg_write: assert property (
    WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && hit(WB_ADR_I, GPM_P5_CFG_ADR) && WB_SEL_I == 4'hf
    |=> r.p5_cfg == $past(WB_DAT_I[GPM_CFG_BITS-1:0]))
    else $error("function select write lost");
  a_gpio_dir: assert property (
    fn[2] == GPM_FN_GPIO |=> PORT5_OUTPUT_ENABLES[2] == $past(r.p5_dir[2]) && PORT5_PIN_OUT[2] == $past(r.p5_out_val[2]))
    else $error("plain I/O pin does not follow its registers");
  a_tx0_select: assert property (
    fn[0] == GPM_FN_ALT1 |=> PORT5_OUTPUT_ENABLES[0] && PORT5_PIN_OUT[0] == $past(SERIAL0_TX))
    else $error("serial0 transmit not on pin 0");
  a_wdog_select: assert property (
    fn[10] == GPM_FN_ALT1 |=> PORT5_PIN_OUT[10] == $past(WATCHDOG_OUT_N))
    else $error("watchdog not on pin 10");
  a_irq0_route: assert property (
    fn[11] == GPM_FN_ALT1 |=> EXT_INTERRUPT0_N == $past(r.p5_lvl[11]))
    else $error("interrupt 0 not routed from pin 11");
  a_dir_gated: assert property (
    fn[3] != GPM_FN_GPIO |=> !PORT5_OUTPUT_ENABLES[3])
    else $error("output enable active outside plain I/O");
  a_ack_one_cycle: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("bus answer not a single-cycle ack");

  c_cfg_write:  cover property (WB_ACK_O && WB_WE_I && hit(WB_ADR_I, GPM_P5_CFG_ADR));
  c_p4_read:    cover property (WB_ACK_O && !WB_WE_I && hit(WB_ADR_I, GPM_P4_IN_ADR));
  c_kbd_clock:  cover property (fn[4] == GPM_FN_ALT3 ##1 PORT5_OUTPUT_ENABLES[4]);
  c_irq1_low:   cover property (fn[12] == GPM_FN_ALT1 ##1 !EXT_INTERRUPT1_N);

endmodule

// *** verification/gpm_far.sv ***
`timescale 1ns/10ps
// ==========================================
// Far side: package pins seen from outside
// ==========================================
module gpm_far (
  input  wire logic [13:0] pin_o,   // Design drive values, bit 13 is port 4
  input  wire logic [13:0] pin_oe,  // Design drive enables
  input  wire logic [13:0] ext,     // Level an outside driver holds on each pin
  output logic      [13:0] pin_lvl  // Resolved wire level fed back to the design
);
  // Driven pin shows the design value; a released pin follows the outside level
  assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext);
endmodule

// *** verification/tb.sv ***
`timescale 1ns/10ps
// ==========================================
// Bench: bus tasks, pin checks, function tables
// ==========================================
module tb
  import gpm_pkg::*;
;
  logic        CLK, SYS_RST, cyc, stb, we;
  logic [31:0] adr, dat, q;       // Request fields and last read word
  logic [3:0]  sel;
  logic [22:0] s;                 // Peripheral source levels
  logic [13:0] ext;               // Outside pin levels
  wire  [13:0] po, poe, lvl;      // Pin drive, enable and resolved level
  wire  [11:0] r;                 // Peripheral inputs routed from pins
  wire         ack;
  wire  [31:0] rdat;
  int          mismatches, n_tests, k, p;
  // Encoded pin*1000 + code*100 + source or sink index
  int ot[18] = '{100, 4101, 4303, 5202, 5304, 6106, 6214, 6317, 7108, 7215, 7318, 8110, 8216, 8319,
                 9112, 9320, 10121, 10222};
  int it[12] = '{3100, 4202, 5101, 5303, 6104, 7105, 8106, 9107, 9208, 11109, 12110, 12211};

  gpm_top dut (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_ACK_O(ack), .WB_DAT_O(rdat),
    .PORT4_PIN_IN(lvl[13]), .PORT4_PIN_OUT(po[13]), .PORT4_PIN_OE(poe[13]),
    .PORT5_PIN_IN(lvl[12:0]), .PORT5_PIN_OUT(po[12:0]), .PORT5_OUTPUT_ENABLES(poe[12:0]),
    .SERIAL0_TX(s[0]), .SERIAL2_TX(s[1]), .SERIAL1_REQUEST_TO_SEND(s[2]), .KEYBOARD_PORT_CLOCK(s[3]),
    .KEYBOARD_PORT_DATA_OUT(s[4]), .KEYBOARD_PORT_DATA_OE(s[5]), .TWOWIRE0_CLOCK_OUT(s[6]),
    .TWOWIRE0_CLOCK_OE(s[7]), .TWOWIRE0_DATA_OUT(s[8]), .TWOWIRE0_DATA_OE(s[9]),
    .TWOWIRE1_CLOCK_OUT(s[10]), .TWOWIRE1_CLOCK_OE(s[11]), .TWOWIRE1_DATA_OUT(s[12]),
    .TWOWIRE1_DATA_OE(s[13]), .SYNC_SERIAL_FRAME(s[14]), .SYNC_SERIAL_TX(s[15]),
    .SYNC_SERIAL_CLOCK(s[16]), .OUTPUT_A(s[17]), .OUTPUT_B(s[18]), .KEYPAD_ROW_2(s[19]),
    .KEYPAD_ROW_3(s[20]), .WATCHDOG_OUT_N(s[21]), .USB_POWER_ENABLE(s[22]), .SERIAL1_RX(r[0]),
    .SERIAL2_RX(r[1]), .SERIAL1_CLEAR_TO_SEND(r[2]), .KEYBOARD_PORT_DATA_IN(r[3]),
    .TWOWIRE0_CLOCK_IN(r[4]), .TWOWIRE0_DATA_IN(r[5]), .TWOWIRE1_CLOCK_IN(r[6]),
    .TWOWIRE1_DATA_IN(r[7]), .SYNC_SERIAL_RX(r[8]), .EXT_INTERRUPT0_N(r[9]),
    .EXT_INTERRUPT1_N(r[10]), .USB_OVERCURRENT_IN(r[11]));
  gpm_far far (.pin_o(po), .pin_oe(poe), .ext(ext), .pin_lvl(lvl));

  // 25 MHz clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // Compare one value, count and report
  task chk(input logic [31:0] got, input logic [31:0] e);
    n_tests++;
    if (got !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask

  // Classic single cycle; request held until the rising edge that samples ack high
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge CLK);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
    do @(posedge CLK); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task wt(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, far longer than the whole sequence
  initial begin
    repeat (5000) @(posedge CLK);
    mismatches++;
    summarize;
  end

  // ==========================================
  // Main sequence
  // ==========================================
  initial begin
    {cyc, stb, we, adr, dat, sel, s, ext} = '0;
    SYS_RST = 1'b1;
    repeat (4) @(posedge CLK);
    SYS_RST <= 1'b0;
    rd(GPM_P4_OUT_ADR, 32'h0);
    rd(GPM_P5_CFG_ADR, 32'h0);
    wr(GPM_P4_OUT_ADR, 32'hffffffff);
    rd(GPM_P4_OUT_ADR, 32'h400);
    wr(GPM_P4_DIR_ADR, 32'h400);
    wt(6);
    chk(32'({po[13], poe[13]}), 32'h3);
    rd(GPM_P4_IN_ADR, 32'h400);
    wr(GPM_P4_OUT_ADR, 32'h0);
    wt(4);
    chk(32'(po[13]), 32'h0);
    // Released pin held high from outside still reads back
    wr(GPM_P4_DIR_ADR, 32'h0);
    ext <= 14'h2000;
    wt(6);
    rd(GPM_P4_IN_ADR, 32'h400);
    ext <= 14'h0;
    // Plain I/O with every enable set; enables stay set for the tables below
    wr(GPM_P5_DIR_ADR, 32'h1fff);
    wr(GPM_P5_OUT_ADR, 32'h1555);
    wt(4);
    chk(32'({po[12:0], poe[12:0]}), {6'h0, 13'h1555, 13'h1fff});
    wr(GPM_P5_CFG_ADR, 32'hffffffff);
    rd(GPM_P5_CFG_ADR, 32'h3ffffff);
    // Output functions: only documented codes are used
    foreach (ot[k]) begin
      p = ot[k] / 1000;
      wr(GPM_P5_CFG_ADR, 32'((ot[k] / 100) % 10) << (2 * p));
      for (int v = 0; v < 2; v++) begin
        @(posedge CLK);
        // Only the selected source and the enable inputs 5, 7, 9, 11 and 13 go high, so a wrong source shows as a low pin
        s <= v ? (23'h002aa0 | (23'h000001 << (ot[k] % 100))) : 23'h002aa0;
        wt(4);
        chk(32'({po[p], poe[p]}), 32'(v * 2 + 1));
      end
    end
    // Input functions: pin level reaches the peripheral, pin stays released
    @(posedge CLK);
    s <= 23'h0;
    foreach (it[k]) begin
      p = it[k] / 1000;
      wr(GPM_P5_CFG_ADR, 32'((it[k] / 100) % 10) << (2 * p));
      for (int v = 0; v < 2; v++) begin
        @(posedge CLK);
        ext <= v ? 14'h3fff : 14'h0;
        wt(6);
        chk(32'({r[it[k] % 100], poe[p]}), 32'(v * 2));
      end
    end
    summarize;
  end
endmodule
